// *** core/csa_regs.vh ***
`ifndef CSA_REGS_VH
`define CSA_REGS_VH

// register byte offsets
`define CSA_OFS_CTRL 8'h00
`define CSA_OFS_INSTR 8'h04
`define CSA_OFS_ACC 8'h08
`define CSA_OFS_BANK 8'h0c
`define CSA_OFS_STATUS 8'h10
`define CSA_OFS_INDEX 8'h14
`define CSA_OFS_MADDR 8'h18
`define CSA_OFS_MDATA 8'h1c
`define CSA_OFS_WDOG 8'h20
`define CSA_OFS_CYCLES 8'h24

// control and status fields
`define CSA_CTRL_EXT 0
`define CSA_ST_C 0
`define CSA_ST_DC 1
`define CSA_ST_Z 2
`define CSA_ST_OV 3
`define CSA_ST_N 4
`define CSA_ST_PD 5
`define CSA_ST_TO 6
`define CSA_STATUS_RST 7'h60

// instruction decode
`define CSA_OP_CMP 4'h6
`define CSA_CMP_LT 3'h0
`define CSA_CMP_EQ 3'h1
`define CSA_CMP_GT 3'h2
`define CSA_OP_COMPLEMENT_REGISTER 6'h07
`define CSA_OP_DECREMENT_REGISTER 6'h01
`define CSA_OP_DAW 16'h0007
`define CSA_OP_WDCLR 16'h0004
`define CSA_OP_NOP 16'h0000

// alu operation select
`define CSA_ALU_NONE 2'h0
`define CSA_ALU_COMPLEMENT_REGISTER 2'h1
`define CSA_ALU_DECREMENT_REGISTER 2'h2
`define CSA_ALU_DAW 2'h3

// address formation
`define CSA_ACCESS_SPLIT 8'h60
`define CSA_INDEX_LIMIT 8'h5f
`define CSA_SFR_BANK 4'hf

// timing
`define CSA_Q_LAST 2'h3

`endif

// *** core/csa_addr.v ***
`timescale 1ns/1ps
`include "csa_regs.vh"

module csa_addr (
  // operand fields
  input wire a_bit,
  input wire [7:0] file_field,
  input wire ext_en,
  // base registers
  input wire [3:0] bank_select_register,
  input wire [11:0] index_base,
  // result
  output reg [11:0] data_addr
);

  always @* begin
    if (a_bit) begin
      data_addr = {bank_select_register, file_field}; // RULE7
    end else if (ext_en && (file_field <= `CSA_INDEX_LIMIT)) begin
      data_addr = index_base + {4'h0, file_field}; // RULE8
    end else if (file_field < `CSA_ACCESS_SPLIT) begin
      data_addr = {4'h0, file_field}; // RULE6
    end else begin
      data_addr = {`CSA_SFR_BANK, file_field}; // RULE6
    end
  end

endmodule

// *** core/csa_alu.v ***
`timescale 1ns/1ps
`include "csa_regs.vh"

module csa_alu (
  // operands
  input wire [1:0] op,
  input wire [7:0] opnd,
  input wire [7:0] acc,
  input wire c_in,
  input wire dc_in,
  // results
  output reg [7:0] result,
  output reg c_out,
  output reg dc_out,
  output reg ov_out,
  output wire n_out,
  output wire z_out,
  output wire f_eq,
  output wire f_gt,
  output wire f_lt
);

  reg [4:0] lo;
  reg [4:0] hi;
  wire [8:0] diff;

  // unsigned subtraction f - acc; borrow marks f < acc
  assign diff = {1'b0, opnd} - {1'b0, acc}; // RULE1
  assign f_eq = (diff == 9'h000); // RULE3
  assign f_lt = diff[8]; // RULE5
  assign f_gt = ~diff[8] & (diff != 9'h000); // RULE4
  assign n_out = result[7];
  assign z_out = (result == 8'h00);

  always @* begin
    result = opnd;
    c_out = c_in;
    dc_out = dc_in;
    ov_out = 1'b0;
    lo = 5'h00;
    hi = 5'h00;
    case (op)
      `CSA_ALU_COMPLEMENT_REGISTER: begin
        result = ~opnd; // RULE10
      end
      `CSA_ALU_DECREMENT_REGISTER: begin
        result = opnd - 8'h01; // RULE11
        c_out = (opnd != 8'h00);
        dc_out = (opnd[3:0] != 4'h0);
        ov_out = (opnd == 8'h80);
      end
      `CSA_ALU_DAW: begin
        lo = {1'b0, acc[3:0]};
        if ((acc[3:0] > 4'h9) || dc_in) begin
          lo = lo + 5'h06; // RULE12
        end
        hi = {1'b0, acc[7:4]} + {4'h0, lo[4]};
        if ((hi > 5'h09) || c_in) begin
          hi = hi + 5'h06; // RULE12
          c_out = 1'b1;
        end
        result = {hi[3:0], lo[3:0]};
      end
      default: begin
        result = opnd;
      end
    endcase
  end

endmodule

// *** core/csa_core.v ***
`timescale 1ns/1ps
`include "csa_regs.vh"

// How it works
// RULE1: compare operations subtract the accumulator from the byte unsigned and touch no flag.
// RULE2: a taken skip turns the next instruction into a no-operation cycle.
// RULE3: equal compare skips only when the byte equals the accumulator.
// RULE4: greater compare skips only when the byte is strictly above the accumulator.
// RULE5: less compare skips only when the byte is strictly below the accumulator.
// RULE6: with the bank-access bit clear the access bank is addressed.
// RULE7: with the bank-access bit set the bank select register forms the upper address.
// RULE8: extended mode with bank-access clear and field up to 95 uses indexed offset addressing.
// RULE9: watchdog clear zeroes counter and postscaler and sets expired and sleep bits at once.
// RULE10: complement writes the inverted byte to the chosen destination, updating only N and Z.
// RULE11: decrement writes byte minus one to the chosen destination and updates C, DC, N, OV, Z.
// RULE12: decimal adjust corrects the low then high nibble by six, carry set on high correction.
// RULE13: a skipped two-word instruction costs two no-operation cycles.
module csa_core (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr
);

  localparam [1:0] Q1 = 2'h0;
  localparam [1:0] Q2 = 2'h1;
  localparam [1:0] Q3 = 2'h2;
  localparam [1:0] Q4 = 2'h3;

  // data memory, 16 banks of 256 bytes
  reg [7:0] mem [0:4095];

  // software visible state
  reg ext_en_r;
  reg [7:0] accumulator_reg;
  reg [3:0] bank_select_register;
  reg [11:0] index_base_r;
  reg [11:0] maddr_r;
  reg [31:0] cycles_r;
  reg carry_flag_r;
  reg digit_carry_flag;
  reg zero_flag_r;
  reg overflow_flag;
  reg negative_flag_r;
  reg watchdog_expired_flag;
  reg sleep_entered_flag;
  reg [7:0] watchdog_counter;
  reg [7:0] wdog_post_r;

  // execution state
  reg busy_r;
  reg [1:0] q_r;
  reg [15:0] ir_r;
  reg nop_r;
  reg squash_r;
  reg [11:0] addr_r;
  reg [7:0] opnd_r;
  reg [7:0] res_r;
  reg [4:0] flags_r;
  reg skip_r;

  // apb state
  wire acc_phase;
  wire take;
  wire wr_en;
  reg [31:0] rd_val;
  reg rd_err;

  // decode
  wire is_cmp;
  wire is_complement_register;
  wire is_decrement_register;
  wire is_daw;
  wire is_wdclr;
  wire two_word;
  wire dest_file;
  reg [1:0] alu_op;
  wire [11:0] addr_w;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_ov;
  wire alu_n;
  wire alu_z;
  wire f_eq;
  wire f_gt;
  wire f_lt;
  reg skip_w;
  wire [6:0] status_w;
  wire commit_w;
  wire wdclr_fire;
  wire file_wb;

  assign is_cmp = (ir_r[15:12] == `CSA_OP_CMP) && (ir_r[11:9] <= `CSA_CMP_GT);
  assign is_complement_register = (ir_r[15:10] == `CSA_OP_COMPLEMENT_REGISTER);
  assign is_decrement_register = (ir_r[15:10] == `CSA_OP_DECREMENT_REGISTER);
  assign is_daw = (ir_r == `CSA_OP_DAW);
  assign is_wdclr = (ir_r == `CSA_OP_WDCLR);
  assign dest_file = ir_r[9];

  // only a live, unsquashed instruction commits results, and only in its last phase
  assign commit_w = busy_r & (q_r == Q4) & ~nop_r;
  assign wdclr_fire = commit_w & is_wdclr; // RULE9
  assign file_wb = commit_w & dest_file & (is_complement_register | is_decrement_register); // RULE10 RULE11

  // a freshly written word that is the first half of a two-word instruction
  assign two_word = (pwdata[15:12] == 4'hc) || (pwdata[15:9] == 7'h76) ||
                    (pwdata[15:8] == 8'hee) || (pwdata[15:8] == 8'hef);

  // a squashed word drives no alu operation
  always @* begin
    if (nop_r) begin
      alu_op = `CSA_ALU_NONE;
    end else if (is_complement_register) begin
      alu_op = `CSA_ALU_COMPLEMENT_REGISTER;
    end else if (is_decrement_register) begin
      alu_op = `CSA_ALU_DECREMENT_REGISTER;
    end else if (is_daw) begin
      alu_op = `CSA_ALU_DAW;
    end else begin
      alu_op = `CSA_ALU_NONE;
    end
  end

  // only the three compare codes can raise a skip
  always @* begin
    case (ir_r[11:9])
      `CSA_CMP_EQ: skip_w = f_eq; // RULE3
      `CSA_CMP_GT: skip_w = f_gt; // RULE4
      `CSA_CMP_LT: skip_w = f_lt; // RULE5
      default: skip_w = 1'b0;
    endcase
  end

  // operand address is formed from the word held in ir_r
  csa_addr u_addr (
    .a_bit(ir_r[8]),
    .file_field(ir_r[7:0]),
    .ext_en(ext_en_r),
    .bank_select_register(bank_select_register),
    .index_base(index_base_r),
    .data_addr(addr_w)
  );

  csa_alu u_alu (
    .op(alu_op),
    .opnd(opnd_r),
    .acc(accumulator_reg),
    .c_in(carry_flag_r),
    .dc_in(digit_carry_flag),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .ov_out(alu_ov),
    .n_out(alu_n),
    .z_out(alu_z),
    .f_eq(f_eq),
    .f_gt(f_gt),
    .f_lt(f_lt)
  );

  // apb: writes wait while an instruction runs so state has one owner
  assign acc_phase = psel & penable & ~pready;
  assign take = acc_phase & ~(pwrite & busy_r);
  assign wr_en = psel & penable & pready & pwrite;

  // status layout from high to low: expired, sleep, n, ov, z, dc, c
  assign status_w = {watchdog_expired_flag, sleep_entered_flag, negative_flag_r,
                     overflow_flag, zero_flag_r, digit_carry_flag, carry_flag_r};

  // unmapped offsets answer with pslverr and zero data
  always @* begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `CSA_OFS_CTRL: rd_val = {31'h0, ext_en_r};
      `CSA_OFS_INSTR: rd_val = {14'h0, squash_r, busy_r, ir_r};
      `CSA_OFS_ACC: rd_val = {24'h0, accumulator_reg};
      `CSA_OFS_BANK: rd_val = {28'h0, bank_select_register};
      `CSA_OFS_STATUS: rd_val = {25'h0, status_w};
      `CSA_OFS_INDEX: rd_val = {20'h0, index_base_r};
      `CSA_OFS_MADDR: rd_val = {20'h0, maddr_r};
      `CSA_OFS_MDATA: rd_val = {24'h0, mem[maddr_r]};
      `CSA_OFS_WDOG: rd_val = {16'h0, wdog_post_r, watchdog_counter};
      `CSA_OFS_CYCLES: rd_val = cycles_r;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= take;
      pslverr <= take & rd_err;
      // zero outside the answer cycle so the bus never shows a stale value
      if (take && !pwrite) begin
        prdata <= rd_val;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // data memory has no reset; only one writer per cycle since writes stall while busy
  always @(posedge pclk) begin
    if (wr_en && (paddr == `CSA_OFS_MDATA)) begin
      mem[maddr_r] <= pwdata[7:0];
    end else if (file_wb) begin
      mem[addr_r] <= res_r; // RULE10
    end
  end

  // free-running watchdog with an 8-bit postscaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter <= 8'h00;
      wdog_post_r <= 8'h00;
    end else if (wdclr_fire) begin
      watchdog_counter <= 8'h00; // RULE9
      wdog_post_r <= 8'h00; // RULE9
    end else begin
      watchdog_counter <= watchdog_counter + 8'h01;
      if (watchdog_counter == 8'hff) begin
        wdog_post_r <= wdog_post_r + 8'h01;
      end
    end
  end

  // register file, sequencer and flag commit share one owner
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_en_r <= 1'b0;
      accumulator_reg <= 8'h00;
      bank_select_register <= 4'h0;
      index_base_r <= 12'h000;
      maddr_r <= 12'h000;
      cycles_r <= 32'h0000_0000;
      {watchdog_expired_flag, sleep_entered_flag, negative_flag_r, overflow_flag,
       zero_flag_r, digit_carry_flag, carry_flag_r} <= `CSA_STATUS_RST;
      busy_r <= 1'b0;
      q_r <= Q1;
      ir_r <= `CSA_OP_NOP;
      nop_r <= 1'b0;
      squash_r <= 1'b0;
      addr_r <= 12'h000;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      flags_r <= 5'h00;
      skip_r <= 1'b0;
    end else begin
      if (wr_en) begin
        case (paddr)
          `CSA_OFS_CTRL: ext_en_r <= pwdata[`CSA_CTRL_EXT];
          `CSA_OFS_ACC: accumulator_reg <= pwdata[7:0];
          `CSA_OFS_BANK: bank_select_register <= pwdata[3:0];
          `CSA_OFS_INDEX: index_base_r <= pwdata[11:0];
          `CSA_OFS_MADDR: maddr_r <= pwdata[11:0];
          `CSA_OFS_CYCLES: cycles_r <= pwdata;
          `CSA_OFS_STATUS: begin
            {watchdog_expired_flag, sleep_entered_flag, negative_flag_r, overflow_flag,
             zero_flag_r, digit_carry_flag, carry_flag_r} <= pwdata[6:0];
          end
          `CSA_OFS_INSTR: begin
            ir_r <= pwdata[15:0];
            busy_r <= 1'b1;
            q_r <= Q1;
            nop_r <= squash_r; // RULE2
            // a squashed first word keeps the squash for its second word
            squash_r <= squash_r & two_word; // RULE13
          end
          default: begin
            ext_en_r <= ext_en_r;
          end
        endcase
      end else if (busy_r) begin
        q_r <= q_r + 2'h1;
        case (q_r)
          Q1: begin
            // decode: resolve the operand address
            addr_r <= addr_w;
          end
          Q2: begin
            // read the addressed byte
            opnd_r <= mem[addr_r];
          end
          Q3: begin
            // results held back so nothing lands before the last phase
            res_r <= alu_res;
            flags_r <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
            skip_r <= ~nop_r & is_cmp & skip_w;
          end
          Q4: begin
            // commit phase; every issued word counts, squashed ones too
            busy_r <= 1'b0;
            cycles_r <= cycles_r + 32'h0000_0001;
            if (skip_r) begin
              squash_r <= 1'b1; // RULE2
            end
            if (!nop_r) begin
              if (is_wdclr) begin
                watchdog_expired_flag <= 1'b1; // RULE9
                sleep_entered_flag <= 1'b1; // RULE9
              end
              if (is_complement_register) begin
                negative_flag_r <= flags_r[4]; // RULE10
                zero_flag_r <= flags_r[2];
                if (!dest_file) begin
                  accumulator_reg <= res_r;
                end
              end
              if (is_decrement_register) begin
                {negative_flag_r, overflow_flag, zero_flag_r, digit_carry_flag,
                 carry_flag_r} <= flags_r; // RULE11
                if (!dest_file) begin
                  accumulator_reg <= res_r;
                end
              end
              if (is_daw) begin
                accumulator_reg <= res_r; // RULE12
                carry_flag_r <= flags_r[0];
              end
            end
          end
          default: begin
            q_r <= Q1;
          end
        endcase
      end
    end
  end

endmodule

// *** tb/csa_core_assertions.sv ***
`timescale 1ns/1ps
`include "csa_regs.vh"

module csa_core_assertions (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  // apb answer
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_done;
    pready && psel && penable;
  endsequence
  sequence s_instr_wr;
    s_done ##0 (pwrite && paddr == `CSA_OFS_INSTR);
  endsequence

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
    else $error("pready without access phase");
  a_answer_bound: assert property (psel && penable && !pready |-> ##[1:7] pready)
    else $error("no answer in time");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (s_done ##0 (paddr > `CSA_OFS_CYCLES) |-> pslverr)
    else $error("unmapped address not refused");
  a_mapped_ok: assert property (s_done ##0 (paddr <= `CSA_OFS_CYCLES && paddr[1:0] == 2'h0)
    |-> !pslverr)
    else $error("mapped address refused");
  a_status_width: assert property (s_done ##0 (!pwrite && paddr == `CSA_OFS_STATUS)
    |-> prdata[31:7] == 25'h0)
    else $error("status upper bits set");
  a_write_rdata: assert property (s_done ##0 pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  // an instruction occupies four cycles, so issue words cannot complete closer
  a_instr_spacing: assert property (s_instr_wr |=>
    (!(pready && pwrite && paddr == `CSA_OFS_INSTR)) [*3])
    else $error("instruction words too close");
endmodule

bind csa_core csa_core_assertions u_csa_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
);

// *** tb/test_compare_skip_adjust_execution.sv ***
`timescale 1ns/1ps
`include "csa_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module test_compare_skip_adjust_execution;
  typedef struct packed {
    logic c;
    logic [3:0] b;
    logic [11:0] ma;
    logic [7:0] md, ac;
    logic [6:0] st;
    logic [15:0] ins;
    logic [7:0] xa, xm;
    logic [6:0] xs;
    logic xk;
  } csa_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, d;
  wire pready, pslverr;
  wire [31:0] prdata;
  int fails = 0, check_count = 0, cyc = 0;
  csa_row_t r;
  // ctrl, bank, addr, mem, acc, status, word -> acc, mem, status, skip
  csa_row_t rows[21] = '{
    '{0, 0, 'h010, 'h33, 'h33, 'h7f, 'h6210, 'h33, 'h33, 'h7f, 1},
    '{0, 0, 'h010, 'h34, 'h33, 'h60, 'h6210, 'h33, 'h34, 'h60, 0},
    '{0, 0, 'h010, 'h80, 'h7f, 'h60, 'h6410, 'h7f, 'h80, 'h60, 1},
    '{0, 0, 'h010, 'h7f, 'h80, 'h60, 'h6410, 'h80, 'h7f, 'h60, 0},
    '{0, 0, 'h010, 'h80, 'h80, 'h60, 'h6410, 'h80, 'h80, 'h60, 0},
    '{0, 0, 'h010, 'h7f, 'h80, 'h7f, 'h6010, 'h80, 'h7f, 'h7f, 1},
    '{0, 0, 'h010, 'h80, 'h7f, 'h60, 'h6010, 'h7f, 'h80, 'h60, 0},
    '{0, 0, 'h010, 'h80, 'h80, 'h60, 'h6010, 'h80, 'h80, 'h60, 0},
    '{0, 0, 'h010, 'h13, 'h00, 'h6b, 'h1c10, 'hec, 'h13, 'h7b, 0},
    '{0, 0, 'h010, 'hff, 'h55, 'h70, 'h1e10, 'h55, 'h00, 'h64, 0},
    '{0, 0, 'h010, 'h01, 'h00, 'h60, 'h0610, 'h00, 'h00, 'h67, 0},
    '{0, 0, 'h010, 'h00, 'h00, 'h60, 'h0410, 'hff, 'h00, 'h70, 0},
    '{0, 0, 'h010, 'h80, 'h00, 'h60, 'h0410, 'h7f, 'h80, 'h69, 0},
    '{0, 0, 'h010, 'h00, 'ha5, 'h60, 'h0007, 'h05, 'h00, 'h61, 0},
    '{0, 0, 'h010, 'h00, 'hce, 'h60, 'h0007, 'h34, 'h00, 'h61, 0},
    '{0, 0, 'h010, 'h00, 'h19, 'h62, 'h0007, 'h1f, 'h00, 'h62, 0},
    '{0, 0, 'hf70, 'h22, 'h00, 'h60, 'h1c70, 'hdd, 'h22, 'h70, 0},
    '{0, 3, 'h310, 'h33, 'h00, 'h60, 'h1d10, 'hcc, 'h33, 'h70, 0},
    '{1, 0, 'h110, 'h44, 'h00, 'h60, 'h1c10, 'hbb, 'h44, 'h70, 0},
    '{1, 0, 'h15f, 'h55, 'h00, 'h60, 'h1c5f, 'haa, 'h55, 'h70, 0},
    '{1, 0, 'hf60, 'h66, 'h00, 'h60, 'h1c60, 'h99, 'h66, 'h70, 0}};

  always #5 pclk = ~pclk;

  csa_core dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
  );

  // pready is sampled before the design's own updates at the same edge land
  task xfer(input [7:0] a, input w, input [31:0] wd, output [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR %0t: no pready", $time);
    end
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    logic [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask
  task rd(input [7:0] a);
    xfer(a, 1'b0, 32'h0, d);
  endtask
  task run(input [15:0] w);
    int n;
    wr(`CSA_OFS_INSTR, 32'(w));
    n = 0;
    do begin
      rd(`CSA_OFS_INSTR);
      n++;
    end while (d[16] !== 1'b0 && n < 20);
    if (d[16] !== 1'b0) begin
      fails++;
      $display("ERROR %0t: instruction hung", $time);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      $display("ERROR %0t: timeout", $time);
      test_done;
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(`CSA_OFS_STATUS);
    `CHK(d, 32'h60)
    rd(`CSA_OFS_ACC);
    `CHK(d, 32'h0)
    rd(8'h28);
    `CHK({err, d}, 33'h100000000)
    wr(8'h28, 32'hff);
    `CHK(err, 1'b1)
    $display("test reset done");
    wr(`CSA_OFS_INDEX, 32'h100);
    foreach (rows[i]) begin
      r = rows[i];
      wr(`CSA_OFS_CTRL, 32'(r.c));
      wr(`CSA_OFS_BANK, 32'(r.b));
      wr(`CSA_OFS_MADDR, 32'(r.ma));
      wr(`CSA_OFS_MDATA, 32'(r.md));
      wr(`CSA_OFS_ACC, 32'(r.ac));
      wr(`CSA_OFS_STATUS, 32'(r.st));
      run(r.ins);
      rd(`CSA_OFS_ACC);
      `CHK(d, 32'(r.xa))
      rd(`CSA_OFS_MDATA);
      `CHK(d, 32'(r.xm))
      rd(`CSA_OFS_STATUS);
      `CHK(d, 32'(r.xs))
      rd(`CSA_OFS_INSTR);
      `CHK(d[17], r.xk)
      run(`CSA_OP_NOP);
    end
    $display("test table done");
    wr(`CSA_OFS_CTRL, 32'h0);
    wr(`CSA_OFS_CYCLES, 32'h0);
    wr(`CSA_OFS_MADDR, 32'h010);
    wr(`CSA_OFS_MDATA, 32'h33);
    wr(`CSA_OFS_ACC, 32'h33);
    run(16'h6210);
    run(16'h0410);
    rd(`CSA_OFS_ACC);
    `CHK(d, 32'h33)
    rd(`CSA_OFS_INSTR);
    `CHK(d[17], 1'b0)
    run(16'h6210);
    run(16'hef00);
    run(16'h0410);
    rd(`CSA_OFS_ACC);
    `CHK(d, 32'h33)
    run(16'h0410);
    rd(`CSA_OFS_ACC);
    `CHK(d, 32'h32)
    rd(`CSA_OFS_CYCLES);
    `CHK(d, 32'h6)
    $display("test skip done");
    wr(`CSA_OFS_INSTR, 32'h0610);
    wr(`CSA_OFS_INSTR, 32'h0610);
    run(`CSA_OP_NOP);
    rd(`CSA_OFS_MDATA);
    `CHK(d, 32'h31)
    $display("test stall done");
    wr(`CSA_OFS_STATUS, 32'h0);
    run(`CSA_OP_WDCLR);
    rd(`CSA_OFS_STATUS);
    `CHK(d, 32'h60)
    rd(`CSA_OFS_WDOG);
    `CHK(d[31:8], 24'h0)
    `CHK(d[7:0] < 8'h40, 1'b1)
    $display("test watchdog done");
    wr(`CSA_OFS_ACC, 32'h5a);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(`CSA_OFS_ACC);
    `CHK(d, 32'h0)
    rd(`CSA_OFS_STATUS);
    `CHK(d, 32'h60)
    $display("test second reset done");
    test_done;
  end
endmodule
